// ### core/arf_formatter.sv
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module arf_formatter
    import arf_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        result_valid,
    input  wire arf_result_t result_in,
    output logic      [31:0] conversion_result_word,
    output logic             word_valid,
    output logic             ref_internal_en,
    output logic             ref_positive_pin_oe
);
    // Raw result: signed count of LSbs (gain already applied upstream)
    logic [2:0]  cfg_ff;
    logic [31:0] word_ff;
    logic        vld_ff;
    logic        refen_ff;
    logic        wr_pend_ff;
    logic [31:0] wr_addr_ff;
    logic [31:0] rd_ff;
    logic [31:0] nxt_word;
    logic [23:0] c24;
    logic [24:0] c25;
    logic signed [31:0] rs;
    arf_fmt_t    fmt;

    assign fmt = arf_fmt_t'(cfg_ff[ARF_CFG_FMT_LO +: 2]);
    assign rs  = signed'(result_in.raw);

    // (R09) 24-bit clamp
    always_comb begin
        if (rs > 32'sd8388607)
            c24 = ARF_P24_MAX;
        else if (rs < -32'sd8388608)
            c24 = ARF_P24_MIN;
        else
            c24 = rs[23:0];
    end

    // (R02) extended range clamp, (R03) (R04) (R05) (R10)
    always_comb begin
        if (rs > 32'sd16777215)
            c25 = ARF_P25_MAX;
        else if (rs < -32'sd16777216)
            c25 = ARF_P25_MIN;
        else
            c25 = rs[24:0];
    end

    // (R01) word layout per format
    always_comb begin
        case (fmt)
            // (R14) bare 24-bit
            ARF_FMT_24:    nxt_word = {8'h00, c24};
            // (R15) left-justified
            ARF_FMT_24_LJ: nxt_word = {c24, 8'h00};
            // (R06) sign-extended right-justified
            ARF_FMT_25_SX: nxt_word = {{7{c25[24]}}, c25};
            // (R07) (R08) tag then four sign copies
            ARF_FMT_25_TAG: nxt_word = {(result_in.scan_mode ? result_in.channel_tag : 4'h0),
                                        {3{c25[24]}}, c25};
            default:       nxt_word = {8'h00, c24};
        endcase
    end

    // (R16) format sampled with the result
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word_ff <= 32'h0000_0000;
            vld_ff  <= 1'b0;
        end else begin
            vld_ff <= result_valid;
            if (result_valid)
                word_ff <= nxt_word;
        end
    end

    // AHB-Lite address phase capture
    logic addr_ok;
    assign addr_ok = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= addr_ok && hwrite;
            if (addr_ok)
                wr_addr_ff <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            cfg_ff <= ARF_CFG_RST;
        else if (wr_pend_ff && wr_addr_ff == ARF_ADDR_CFG)
            cfg_ff <= hwdata[2:0];
    end

    // (R12) (R13) reference source steering
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            refen_ff <= 1'b0;
        else
            refen_ff <= cfg_ff[ARF_CFG_REFSEL];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            rd_ff <= 32'h0000_0000;
        else if (addr_ok && !hwrite) begin
            case (haddr)
                ARF_ADDR_DATA: rd_ff <= word_ff;
                ARF_ADDR_CFG:  rd_ff <= {29'h0, cfg_ff};
                ARF_ADDR_STAT: rd_ff <= {31'h0, refen_ff};
                default:       rd_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata                 = rd_ff;
    assign hreadyout              = 1'b1;
    assign hresp                  = 1'b0;
    assign conversion_result_word = word_ff;
    assign word_valid             = vld_ff;
    assign ref_internal_en        = refen_ff;
    assign ref_positive_pin_oe    = refen_ff;

    // (R03) positive clamp
    a_pos_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
        result_valid && fmt == ARF_FMT_25_SX && rs > 32'sd16777215
        |=> word_ff == 32'h00FFFFFF) else $error("25-bit positive clamp wrong"); // (R03)
    // (R04) negative clamp
    a_neg_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
        result_valid && fmt == ARF_FMT_25_SX && rs < -32'sd16777216
        |=> word_ff == 32'hFF000000) else $error("25-bit negative clamp wrong"); // (R04)
    // (R09) 24-bit clamp
    a_clamp_24: assert property (@(posedge hclk) disable iff (!hresetn)
        result_valid && fmt == ARF_FMT_24 && rs > 32'sd8388607
        |=> word_ff == 32'h007FFFFF) else $error("24-bit clamp wrong"); // (R09)
    // (R15) low byte zero
    a_lj_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        result_valid && fmt == ARF_FMT_24_LJ |=> word_ff[7:0] == 8'h00)
        else $error("left-justified low byte not zero"); // (R15)
    // (R06) sign fill
    a_sign_fill: assert property (@(posedge hclk) disable iff (!hresetn)
        result_valid && fmt == ARF_FMT_25_SX
        |=> word_ff[31:24] == {8{word_ff[24]}}) else $error("sign fill wrong"); // (R06)
    // (R08) tag zero in mux mode
    a_tag_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        result_valid && fmt == ARF_FMT_25_TAG && !result_in.scan_mode
        |=> word_ff[31:28] == 4'h0) else $error("tag not zero"); // (R08)
    // (R05) low 24 bits agree
    a_low_agree: assert property (@(posedge hclk) disable iff (!hresetn)
        result_valid && fmt[1] && rs <= 32'sd8388607 && rs >= -32'sd8388608
        |=> word_ff[23:0] == $past(c24)) else $error("low bits disagree"); // (R05)
    // (R13) pin follows select
    a_ref_pin: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 ref_positive_pin_oe == $past(cfg_ff[ARF_CFG_REFSEL]))
        else $error("reference pin direction wrong"); // (R13)
    // (R16) word held between results
    a_word_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !result_valid |=> $stable(word_ff)) else $error("word changed without result"); // (R16)

    // Result capture under each format
    sequence s_take_24;
        result_valid && fmt == ARF_FMT_24;
    endsequence

    sequence s_take_lj;
        result_valid && fmt == ARF_FMT_24_LJ;
    endsequence

    sequence s_take_wide;
        result_valid && fmt[1];
    endsequence

    sequence s_take_tag_scan;
        result_valid && fmt == ARF_FMT_25_TAG && result_in.scan_mode;
    endsequence

    // Config write: address phase then data phase
    sequence s_cfg_write;
        addr_ok && hwrite && haddr == ARF_ADDR_CFG ##1 1'b1;
    endsequence

    // Data read address phase
    sequence s_data_read;
        addr_ok && !hwrite && haddr == ARF_ADDR_DATA;
    endsequence

    // (R14) bare 24-bit word
    a_bare_24: assert property (@(posedge hclk) disable iff (!hresetn)
        s_take_24 |=> word_ff == {8'h00, $past(c24)})
        else $error("bare 24-bit word wrong"); // (R14)
    // (R15) left-justified body
    a_lj_body: assert property (@(posedge hclk) disable iff (!hresetn)
        s_take_lj |=> word_ff[31:8] == $past(c24))
        else $error("left-justified body wrong"); // (R15)
    // (R01) 25-bit value in the low bits
    a_wide_value: assert property (@(posedge hclk) disable iff (!hresetn)
        s_take_wide |=> word_ff[24:0] == $past(c25))
        else $error("25-bit value wrong"); // (R01)
    // (R02) overrange kept, not clipped
    a_ovr_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        s_take_wide && rs > 32'sd8388607 && rs <= 32'sd16777215
        |=> word_ff[24:0] == $past(rs[24:0]))
        else $error("overrange value clipped"); // (R02)
    // (R07) channel tag then sign copies
    a_tag_scan: assert property (@(posedge hclk) disable iff (!hresetn)
        s_take_tag_scan
        |=> word_ff[31:28] == $past(result_in.channel_tag)
            && word_ff[27:24] == {4{$past(c25[24])}})
        else $error("tagged layout wrong"); // (R07)
    // (R09) 24-bit negative clamp
    a_neg_24: assert property (@(posedge hclk) disable iff (!hresetn)
        s_take_24 && rs < -32'sd8388608 |=> word_ff == 32'h00800000)
        else $error("24-bit negative clamp wrong"); // (R09)
    // (R10) plus one reference in 25-bit
    a_plus_ref: assert property (@(posedge hclk) disable iff (!hresetn)
        result_valid && fmt == ARF_FMT_25_SX && rs == 32'sd8388608
        |=> word_ff == 32'h00800000)
        else $error("plus reference code wrong"); // (R10)
    // (R16) valid pulse follows capture
    a_vld_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
        result_valid |=> word_valid)
        else $error("word valid missing"); // (R16)
    // (R12) external reference: buffer off, pin input
    a_ref_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !cfg_ff[ARF_CFG_REFSEL] |=> !ref_internal_en && !ref_positive_pin_oe)
        else $error("external reference steering wrong"); // (R12)
    // (R13) buffer and pin direction agree
    a_ref_pair: assert property (@(posedge hclk) disable iff (!hresetn)
        ref_internal_en == ref_positive_pin_oe)
        else $error("buffer and pin direction disagree"); // (R13)
    // (R16) config write lands after data phase
    a_cfg_land: assert property (@(posedge hclk) disable iff (!hresetn)
        s_cfg_write |=> cfg_ff == $past(hwdata[2:0]))
        else $error("config write lost"); // (R16)
    // (R16) data read returns latched word
    a_rd_word: assert property (@(posedge hclk) disable iff (!hresetn)
        s_data_read |=> hrdata == $past(word_ff))
        else $error("data read wrong"); // (R16)
endmodule
`default_nettype wire

// ### core/arf_pkg.sv
// Summary of operation
// (R01) Format select upper bit 1: result is 25-bit signed in a 32-bit word.
// (R02) 25-bit formats accept results up to about twice the reference.
// (R03) 25-bit: above 2*Vref - 1 LSb clamps to 0x0FFFFFF.
// (R04) 25-bit: below -2*Vref clamps to 0x1000000.
// (R05) Inside +/-Vref the 25-bit low 24 bits equal the 24-bit code.
// (R06) Code 10: 25-bit value right-justified, top byte holds sign copies.
// (R07) Code 11: like 10 but top four bits carry the channel tag.
// (R08) Channel tag is zero in single-mux mode, channel number in scan.
// (R09) 24-bit formats: two's complement, clamp 0x7FFFFF and 0x800000.
// (R10) 25-bit: +Vref gives 0x0800000, -Vref 0x1800000, -1 LSb 0x1FFFFFF.
// (R11) DC code equals Vin/Vref times 8388608 times gain.
// (R12) Reference select 0: external reference, pin input, buffer off.
// (R13) Reference select 1: internal 2.4V buffered reference, pin output.
// (R14) Code 00: word is the bare 24-bit result.
// (R15) Code 01: 24-bit result left-justified, low byte zero.
// (R16) Format in force when a result is latched applies to that word.
package arf_pkg;
    localparam int          ARF_RAW_W      = 32;
    localparam int          ARF_FULL_SCALE = 8388608;
    localparam logic [31:0] ARF_ADDR_DATA  = 32'h0000_0000;
    localparam logic [31:0] ARF_ADDR_CFG   = 32'h0000_0004;
    localparam logic [31:0] ARF_ADDR_STAT  = 32'h0000_0008;
    localparam logic [2:0]  ARF_CFG_RST    = 3'h0;
    localparam int          ARF_CFG_FMT_LO = 0;
    localparam int          ARF_CFG_REFSEL = 2;
    localparam logic [23:0] ARF_P24_MAX    = 24'h7FFFFF;
    localparam logic [23:0] ARF_P24_MIN    = 24'h800000;
    localparam logic [24:0] ARF_P25_MAX    = 25'h0FFFFFF;
    localparam logic [24:0] ARF_P25_MIN    = 25'h1000000;

    typedef enum logic [1:0] {
        ARF_FMT_24, ARF_FMT_24_LJ, ARF_FMT_25_SX, ARF_FMT_25_TAG
    } arf_fmt_t;

    typedef struct packed {
        logic [31:0] raw;
        logic [3:0]  channel_tag;
        logic        scan_mode;
    } arf_result_t;
endpackage

// ### tb/arf_result_src.sv
`timescale 1ns/1ps
`default_nettype none
module arf_result_src
    import arf_pkg::*;
(
    input  wire logic  hclk,
    output logic       result_valid,
    output arf_result_t result_in
);
    initial begin
        result_valid = 1'b0;
        result_in    = '0;
    end
    task automatic send(input logic [31:0] raw, input logic [3:0] tag, input logic scan);
        @(posedge hclk);
        result_valid <= 1'b1;
        result_in    <= '{raw, tag, scan};
        @(posedge hclk);
        result_valid <= 1'b0;
        // Stale result inverted once released
        result_in    <= ~result_in;
    endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import arf_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, result_valid, word_valid;
    logic        ref_internal_en, ref_positive_pin_oe;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, conversion_result_word, q, e;
    arf_result_t result_in;
    int          err_total, comparisons;
    logic signed [31:0] vals [5] = '{32'sh800000, -32'sh800000, -32'sh1, 32'sh1000000,
                                     -32'sh1000001};
    assign hready = hreadyout;
    arf_result_src src_u (.hclk(hclk), .result_valid(result_valid), .result_in(result_in));
    arf_formatter dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .result_valid(result_valid),
        .result_in(result_in), .conversion_result_word(conversion_result_word),
        .word_valid(word_valid), .ref_internal_en(ref_internal_en),
        .ref_positive_pin_oe(ref_positive_pin_oe));
    always #25 hclk = ~hclk;
    task automatic summarize();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wait_hi(input logic sel);
        int n;
        n = 0;
        do begin
            // Result pulse is read mid-cycle, bus handshake on the edge
            if (sel)
                @(negedge hclk);
            else
                @(posedge hclk);
            n++;
        end while ((sel ? word_valid : hreadyout) !== 1'b1 && n < 50);
        if ((sel ? word_valid : hreadyout) !== 1'b1) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_hi(1'b0);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_hi(1'b0);
        q = hrdata;
    endtask
    function automatic logic [31:0] fmt_exp(logic [1:0] f, logic signed [31:0] r, logic s);
        logic signed [31:0] c24, c25;
        c24 = r > 32'sh7FFFFF ? 32'sh7FFFFF : (r < -32'sh800000 ? -32'sh800000 : r);
        c25 = r > 32'shFFFFFF ? 32'shFFFFFF : (r < -32'sh1000000 ? -32'sh1000000 : r);
        case (f)
            2'h0: return {8'h00, c24[23:0]};
            2'h1: return {c24[23:0], 8'h00};
            2'h2: return c25;
            default: return {s ? 4'hA : 4'h0, {4{c25[24]}}, c25[23:0]};
        endcase
    endfunction
    initial begin
        {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, ARF_ADDR_CFG, 32'h0);
        chk("cfg_reset", q, 32'h0);
        chk("ref_en_reset", {30'h0, ref_internal_en, ref_positive_pin_oe}, 32'h0);
        for (int f = 0; f < 4; f++) begin
            for (int i = 0; i < 5; i++) begin
                ahb(1'b1, ARF_ADDR_CFG, f);
                src_u.send(vals[i], 4'hA, i[0]);
                wait_hi(1'b1);
                e = fmt_exp(f[1:0], vals[i], i[0]);
                chk("word", conversion_result_word, e);
                ahb(1'b1, ARF_ADDR_CFG, f ^ 3);
                ahb(1'b0, ARF_ADDR_DATA, 32'h0);
                chk("data_read", q, e);
            end
        end
        for (int r = 1; r >= 0; r--) begin
            ahb(1'b1, ARF_ADDR_CFG, r << ARF_CFG_REFSEL);
            repeat (2) @(posedge hclk);
            chk("ref_out", {30'h0, ref_internal_en, ref_positive_pin_oe}, r * 3);
            ahb(1'b0, ARF_ADDR_STAT, 32'h0);
            chk("stat", q, r);
        end
        ahb(1'b0, 32'h0000_0010, 32'h0);
        chk("unmapped", q, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
